// file: design/memory_scrub_and_scramble.sv
// Functional notes
// - Store 8-bit SEC-DED code per 8 data bytes; recompute on read; zero syndrome is clean.
// - The 72 single-bit syndromes are correctable; other non-zero syndromes are uncorrectable.
// - A correctable read returns corrected data with a correctable-error flag.
// - A correctable flag on returned non-MMIO data marks the receiving entry modified.
// - The scrub writeback stores corrected data with freshly generated check bits.
// - Demand scrub only for DRAM reads; memory-mapped I/O reads never write back.
// - Enabled patrol walks memory from the start address up and wraps back to it, with slow background reads, default start zero.
// - Patrol read data is dropped, never forwarded to a requestor.
// - A correctable patrol read is written back corrected to the same location.
// - Patrol control register holds the engine enable and the scrub period.
// - Default period covers 8 GB in about 24 hours.
// - Patrol skips the low I/O hole; upper limit follows installed memory.
// - Software sets the patrol start through the start-address register.
// - Patrol has lowest priority and never issues during self-refresh.
// - Rate is a ceiling; the interval timer is held at zero while a patrol read waits.
// - Scrambling XORs all 72 bus bits with a pseudo-random, roughly balanced mask.
`timescale 1ns/1ps
`default_nettype none
`include "scrub_cfg.svh"
module memory_scrub_and_scramble #(
  parameter int          ADDR_W       = 32,
  parameter int unsigned SCRUB_PERIOD = int'((64'(`COVER_TIME_S) * 64'(`CLK_HZ))
                                        / (`COVER_BYTES / 64'(`WORD_BYTES)))
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset_n,
  // Sideband register port
  input  wire logic              sb_wr,
  input  wire logic              sb_rd,
  input  wire logic [11:0]       sb_addr,
  input  wire logic [31:0]       sb_wdata,
  output logic      [31:0]       sb_rdata_q,
  output logic                   sb_rvalid_q,
  // Memory map limits in 8-byte words
  input  wire logic [ADDR_W-1:0] mem_top,
  input  wire logic [ADDR_W-1:0] hole_base,
  input  wire logic [ADDR_W-1:0] hole_limit,
  // Requestor side
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic              req_mmio,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [63:0]       req_wdata,
  output logic                   req_ready_q,
  output logic                   rsp_valid_q,
  output logic      [63:0]       rsp_data_q,
  output logic                   rsp_ce_q,
  output logic                   rsp_ue_q,
  output logic                   rsp_dirty_q,
  // DRAM command side
  input  wire logic              self_refresh,
  input  wire logic              dram_cmd_ready,
  input  wire logic              dram_rvalid,
  input  wire logic [71:0]       dram_rdata,
  output logic                   dram_cmd_valid_q,
  output logic                   dram_cmd_write_q,
  output logic      [ADDR_W-1:0] dram_cmd_addr_q,
  output logic      [71:0]       dram_wdata_q
);
  import scrub_pkg::*;

  if (ADDR_W < 8 || ADDR_W > 32)
  begin : g_chk
    $error("ADDR_W must lie between 8 and 32");
  end

  // The reset period is loaded into a 24-bit field; a larger default would be cut silently.
  if (SCRUB_PERIOD >= (64'd1 << `PCTRL_PER_W))
  begin : g_chk_per
    $error("SCRUB_PERIOD must fit the period field");
  end

  // Columns are the first 64 odd-weight bytes of weight three or more, so single errors stay distinct.
  function automatic logic [63:0][7:0] build_h();
    logic [63:0][7:0] h;
    int               n;
    h = '0;
    n = 0;
    for (int v = 0; v < 256; v++)
    begin
      if (($countones(8'(v)) % 2 == 1) && ($countones(8'(v)) >= 3) && (n < 64))
      begin
        h[n] = 8'(v);
        n++;
      end
    end
    return h;
  endfunction
  localparam logic [63:0][7:0] HMAT = build_h();

  function automatic logic [7:0] ecc_gen(input logic [63:0] d);
    logic [7:0] c;
    c = '0;
    for (int i = 0; i < `DATA_W; i++)
    begin
      if (d[i])
      begin
        c = c ^ HMAT[i];
      end
    end
    return c;
  endfunction

  // Mask depends on location only, so a read can rebuild what the write applied.
  function automatic logic [71:0] mask_of(input logic [ADDR_W-1:0] a);
    logic [31:0] s;
    logic [71:0] m;
    s = 32'(a) ^ `SCRM_SEED;
    m = '0;
    for (int i = 0; i < 3; i++)
    begin
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      m[i*24 +: 24] = s[23:0];
    end
    return m;
  endfunction

  st_t                  st_q;
  logic [31:0]          pctrl_q;
  logic [31:0]          pstart_q;
  logic [31:0]          scfg_q;
  logic                 en_d1_q;
  logic [`PCTRL_PER_W-1:0] tmr_q;
  logic                 pend_q;
  logic [ADDR_W-1:0]    paddr_q;
  logic [ADDR_W-1:0]    rd_addr_q;
  logic                 rd_patrol_q;
  logic                 rd_mmio_q;
  logic                 p_en;
  logic                 scr_en;
  logic [`PCTRL_PER_W-1:0] period;
  logic [71:0]          plain;
  logic [7:0]           syn;
  logic [63:0]          fixed;
  logic                 ce;
  logic                 ue;
  logic                 take_req;
  logic                 take_pat;
  logic [ADDR_W-1:0]    pnext;

  assign p_en   = pctrl_q[`PCTRL_EN_BIT];
  assign scr_en = scfg_q[`SCRM_EN_BIT];
  assign period = pctrl_q[`PCTRL_PER_LSB +: `PCTRL_PER_W];
  assign plain  = dram_rdata ^ (scr_en ? mask_of(rd_addr_q) : 72'h0);
  assign syn    = ecc_gen(plain[63:0]) ^ plain[71:64];

  always_comb
  begin
    fixed = plain[63:0];
    ce    = 1'b0;
    ue    = 1'b0;
    if (syn != 8'h00)
    begin
      ue = ($countones(syn) != 1);
      ce = ~ue;
      for (int i = 0; i < `DATA_W; i++)
      begin
        if (syn == HMAT[i])
        begin
          fixed[i] = ~fixed[i];
          ce       = 1'b1;
          ue       = 1'b0;
        end
      end
    end
  end

  // Arbitration: writeback, then demand, then patrol.
  assign take_req = (st_q == ST_IDLE) && !dram_cmd_valid_q && req_valid && req_ready_q;
  assign take_pat = (st_q == ST_IDLE) && !dram_cmd_valid_q && !take_req && !req_valid
                    && pend_q && p_en && !self_refresh;

  always_comb
  begin
    pnext = paddr_q + 1'b1;
    if (pnext >= hole_base && pnext < hole_limit)
    begin
      pnext = hole_limit;
    end
    if (pnext >= mem_top)
    begin
      pnext = ADDR_W'(pstart_q);
    end
  end

  always_ff @(posedge mclk)
  begin
    sb_rvalid_q <= reset_n && sb_rd;
    if (!reset_n)
    begin
      pctrl_q    <= 32'(SCRUB_PERIOD) << `PCTRL_PER_LSB;
      pstart_q   <= 32'h00000000;
      scfg_q     <= 32'h00000000;
      sb_rdata_q <= 32'h00000000;
    end
    else
    begin
      if (sb_wr && sb_addr == `OFS_PATROL_CTRL)
      begin
        pctrl_q <= sb_wdata;
      end
      if (sb_wr && sb_addr == `OFS_PATROL_START)
      begin
        pstart_q <= sb_wdata;
      end
      if (sb_wr && sb_addr == `OFS_SCRAMBLE_CFG)
      begin
        scfg_q <= sb_wdata;
      end
      case (sb_addr)
        `OFS_PATROL_CTRL:  sb_rdata_q <= pctrl_q;
        `OFS_PATROL_START: sb_rdata_q <= pstart_q;
        `OFS_SCRAMBLE_CFG: sb_rdata_q <= scfg_q;
        default:           sb_rdata_q <= 32'h00000000;
      endcase
    end
  end

  // Patrol pacing and address walk.
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      en_d1_q <= 1'b0;
      tmr_q   <= '0;
      pend_q  <= 1'b0;
      paddr_q <= '0;
    end
    else
    begin
      en_d1_q <= p_en;
      if (p_en && !en_d1_q)
      begin
        paddr_q <= ADDR_W'(pstart_q);
        tmr_q   <= '0;
        pend_q  <= 1'b0;
      end
      else if (take_pat)
      begin
        pend_q  <= 1'b0;
        paddr_q <= pnext;
      end
      else if (p_en && !pend_q)
      begin
        if (tmr_q + 1'b1 >= period)
        begin
          tmr_q  <= '0;
          pend_q <= 1'b1;
        end
        else
        begin
          tmr_q <= tmr_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    rsp_valid_q <= 1'b0;
    if (!reset_n)
    begin
      st_q             <= ST_IDLE;
      req_ready_q      <= 1'b0;
      rd_addr_q        <= '0;
      rd_patrol_q      <= 1'b0;
      rd_mmio_q        <= 1'b0;
      rsp_data_q       <= 64'h0;
      rsp_ce_q         <= 1'b0;
      rsp_ue_q         <= 1'b0;
      rsp_dirty_q      <= 1'b0;
      dram_cmd_valid_q <= 1'b0;
      dram_cmd_write_q <= 1'b0;
      dram_cmd_addr_q  <= '0;
      dram_wdata_q     <= 72'h0;
    end
    else
    begin
      req_ready_q <= (st_q == ST_IDLE) && !dram_cmd_valid_q && !take_req && !take_pat;
      if (dram_cmd_valid_q && dram_cmd_ready)
      begin
        dram_cmd_valid_q <= 1'b0;
      end
      case (st_q)
        ST_IDLE:
        begin
          if (take_req || take_pat)
          begin
            dram_cmd_valid_q <= 1'b1;
            dram_cmd_write_q <= take_req && req_write;
            dram_cmd_addr_q  <= take_req ? req_addr : paddr_q;
            dram_wdata_q     <= {ecc_gen(req_wdata), req_wdata}
                                ^ (scr_en ? mask_of(req_addr) : 72'h0);
            rd_addr_q        <= take_req ? req_addr : paddr_q;
            rd_patrol_q      <= take_pat;
            rd_mmio_q        <= take_req && req_mmio;
            if (take_pat || !req_write)
            begin
              st_q <= ST_RD;
            end
          end
        end
        ST_RD:
        begin
          if (dram_rvalid)
          begin
            rsp_valid_q <= !rd_patrol_q;
            // Patrol data must not even overwrite the held response, or a requestor could see it.
            if (!rd_patrol_q)
            begin
              rsp_data_q  <= fixed;
              rsp_ce_q    <= ce;
              rsp_ue_q    <= ue;
              rsp_dirty_q <= ce && !rd_mmio_q;
            end
            if (ce && !rd_mmio_q)
            begin
              st_q             <= ST_WB;
              dram_cmd_valid_q <= 1'b1;
              dram_cmd_write_q <= 1'b1;
              dram_cmd_addr_q  <= rd_addr_q;
              dram_wdata_q     <= {ecc_gen(fixed), fixed}
                                  ^ (scr_en ? mask_of(rd_addr_q) : 72'h0);
            end
            else
            begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_WB:
        begin
          if (dram_cmd_ready)
          begin
            st_q <= ST_IDLE;
          end
        end
        default:
        begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_patrol_dropped: assert property (st_q == ST_RD && dram_rvalid && rd_patrol_q
    |=> !rsp_valid_q) else $error("patrol data forwarded");
  a_patrol_rsp_held: assert property (st_q == ST_RD && dram_rvalid && rd_patrol_q
    |=> $stable(rsp_data_q) && $stable(rsp_ce_q)) else $error("patrol data reached requestor");
  a_mmio_no_wb: assert property (st_q == ST_RD && dram_rvalid && rd_mmio_q
    |=> st_q == ST_IDLE) else $error("mmio read scrubbed");
  a_ce_writeback: assert property (st_q == ST_RD && dram_rvalid && ce && !rd_mmio_q
    |=> st_q == ST_WB && dram_cmd_write_q && dram_cmd_addr_q == $past(rd_addr_q))
    else $error("missing scrub writeback");
  a_wb_fresh_ecc: assert property (dram_cmd_valid_q && dram_cmd_write_q
    |-> ((dram_wdata_q ^ (scr_en ? mask_of(dram_cmd_addr_q) : 72'h0)) >> 64)
        == 72'(ecc_gen(dram_wdata_q[63:0] ^ (scr_en ? mask_of(dram_cmd_addr_q) : 72'h0))))
    else $error("write check bits wrong");
  a_dirty_on_ce: assert property (rsp_valid_q && rsp_ce_q && !$past(rd_mmio_q)
    |-> rsp_dirty_q) else $error("entry not marked modified");
  a_sr_no_patrol: assert property (self_refresh && pend_q && !req_valid
    |=> !(dram_cmd_valid_q && rd_patrol_q && !$past(dram_cmd_valid_q)))
    else $error("patrol issued in self-refresh");
  a_timer_held: assert property (pend_q |-> tmr_q == '0)
    else $error("timer ran while patrol pending");
  a_start_load: assert property (p_en && !en_d1_q |=> paddr_q == ADDR_W'($past(pstart_q)))
    else $error("patrol start not loaded");
  a_ue_no_ce: assert property (rsp_valid_q |-> !(rsp_ce_q && rsp_ue_q))
    else $error("error class ambiguous");
endmodule
`default_nettype wire

// file: design/scrub_cfg.svh
`ifndef SCRUB_CFG_SVH
`define SCRUB_CFG_SVH
`define OFS_PATROL_CTRL   12'h17A
`define OFS_PATROL_START  12'h17B
`define OFS_SCRAMBLE_CFG  12'h17C
`define PCTRL_EN_BIT      0
`define PCTRL_PER_LSB     8
`define PCTRL_PER_W       24
`define SCRM_EN_BIT       16
`define SCRM_SEED         32'h5A3C96E1
`define COVER_TIME_S      86400
`define CLK_HZ            200000000
`define COVER_BYTES       (64'd8 << 30)
`define WORD_BYTES        8
`define DATA_W            64
`define CHK_W             8
`endif

// file: design/scrub_pkg.sv
`default_nettype none
package scrub_pkg;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_RD   = 2'b01,
    ST_WB   = 2'b11
  } st_t;
endpackage
`default_nettype wire

// file: verification/dram_model.sv
`timescale 1ns/1ps
`default_nettype none
// A sixteen-word rank. A bus with no read answer shows the inverse of the last read.
module dram_model #(
  parameter int AW = 8
) (
  // Clock and pacing
  input  wire logic          mclk,
  input  wire logic          slow,
  // Command side
  input  wire logic          cmd_valid,
  input  wire logic          cmd_write,
  input  wire logic [AW-1:0] cmd_addr,
  input  wire logic [71:0]   wdata,
  output logic               cmd_ready,
  // Read return
  output logic               rvalid,
  output logic      [71:0]   rdata
);
  logic [71:0] mem [16];
  logic [71:0] last = '0;
  initial
  begin
    cmd_ready = 1'b0;
    rvalid = 1'b0;
    rdata = '0;
    foreach (mem[i]) mem[i] = '0;
  end
  always @(posedge mclk)
  begin
    rvalid <= 1'b0;
    rdata <= ~last;
    cmd_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
    if (cmd_valid && cmd_ready && cmd_write)
      mem[cmd_addr[3:0]] <= wdata;
    else if (cmd_valid && cmd_ready)
    begin
      rvalid <= 1'b1;
      rdata <= mem[cmd_addr[3:0]];
      last <= mem[cmd_addr[3:0]];
    end
  end
endmodule
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int AW  = 8;
  localparam int PER = 10;
  logic          mclk = 1'b0;
  logic          reset_n = 1'b0;
  logic          sb_wr = 1'b0;
  logic          sb_rd = 1'b0;
  logic [11:0]   sb_addr = '0;
  logic [31:0]   sb_wdata = '0;
  logic [31:0]   sb_rdata_q;
  logic          sb_rvalid_q;
  logic [AW-1:0] mem_top = 8'h10;
  logic [AW-1:0] hole_base = 8'h04;
  logic [AW-1:0] hole_limit = 8'h06;
  logic          req_valid = 1'b0;
  logic          req_write = 1'b0;
  logic          req_mmio = 1'b0;
  logic [AW-1:0] req_addr = '0;
  logic [63:0]   req_wdata = '0;
  logic          req_ready_q, rsp_valid_q, rsp_ce_q, rsp_ue_q, rsp_dirty_q;
  logic [63:0]   rsp_data_q;
  logic          self_refresh = 1'b0;
  logic          slow = 1'b0;
  logic          dram_cmd_ready, dram_rvalid, dram_cmd_valid_q, dram_cmd_write_q;
  logic [71:0]   dram_rdata, dram_wdata_q, wr_data;
  logic [AW-1:0] dram_cmd_addr_q, wr_addr;
  int            fails = 0, n_compared = 0, cycles = 0, n_wr = 0, n_rsp = 0;
  logic [AW-1:0] rd_q[$];
  int            rd_t[$];
  logic          vld_d = 1'b0;
  logic [63:0]   shadow [16];

  always #2.5 mclk = ~mclk;

  memory_scrub_and_scramble #(.ADDR_W(AW), .SCRUB_PERIOD(PER)) memory_scrub_and_scramble_inst (
    .mclk(mclk), .reset_n(reset_n), .sb_wr(sb_wr), .sb_rd(sb_rd), .sb_addr(sb_addr),
    .sb_wdata(sb_wdata), .sb_rdata_q(sb_rdata_q), .sb_rvalid_q(sb_rvalid_q),
    .mem_top(mem_top), .hole_base(hole_base), .hole_limit(hole_limit),
    .req_valid(req_valid), .req_write(req_write), .req_mmio(req_mmio), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready_q(req_ready_q), .rsp_valid_q(rsp_valid_q),
    .rsp_data_q(rsp_data_q), .rsp_ce_q(rsp_ce_q), .rsp_ue_q(rsp_ue_q),
    .rsp_dirty_q(rsp_dirty_q), .self_refresh(self_refresh), .dram_cmd_ready(dram_cmd_ready),
    .dram_rvalid(dram_rvalid), .dram_rdata(dram_rdata), .dram_cmd_valid_q(dram_cmd_valid_q),
    .dram_cmd_write_q(dram_cmd_write_q), .dram_cmd_addr_q(dram_cmd_addr_q),
    .dram_wdata_q(dram_wdata_q));

  dram_model #(.AW(AW)) dram_model_inst (
    .mclk(mclk), .slow(slow), .cmd_valid(dram_cmd_valid_q), .cmd_write(dram_cmd_write_q),
    .cmd_addr(dram_cmd_addr_q), .wdata(dram_wdata_q), .cmd_ready(dram_cmd_ready),
    .rvalid(dram_rvalid), .rdata(dram_rdata));

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [71:0] seen, input logic [71:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (rsp_valid_q === 1'b1) n_rsp++;
    if (dram_cmd_valid_q === 1'b1 && dram_cmd_ready === 1'b1)
    begin
      if (dram_cmd_write_q)
      begin
        n_wr++;
        wr_addr = dram_cmd_addr_q;
        wr_data = dram_wdata_q;
      end
      else
      begin
        rd_q.push_back(dram_cmd_addr_q);
      end
    end
    // Pacing is measured at issue, so a slow sequencer cannot shrink the measured gap.
    if (dram_cmd_valid_q === 1'b1 && dram_cmd_write_q === 1'b0 && !vld_d)
      rd_t.push_back(cycles);
    vld_d = (dram_cmd_valid_q === 1'b1);
    // The whole run needs well under a tenth of this; a hang ends here.
    if (cycles == 20000)
    begin
      fails++;
      final_report();
    end
  end

  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge mclk);
    sb_wr = 1'b1;
    sb_addr = a;
    sb_wdata = d;
    @(negedge mclk);
    sb_wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp);
    @(negedge mclk);
    sb_rd = 1'b1;
    sb_addr = a;
    @(negedge mclk);
    sb_rd = 1'b0;
    chk("sb_rvalid", sb_rvalid_q, 1);
    chk("sb_rdata", sb_rdata_q, exp);
  endtask

  // Returns only once the block is idle again, so any scrub writeback has been seen.
  task automatic req(input logic w, input logic m, input int a, input logic [63:0] d);
    @(negedge mclk);
    req_valid = 1'b1;
    req_write = w;
    req_mmio = m;
    req_addr = AW'(a);
    req_wdata = d;
    while (req_ready_q !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    req_valid = 1'b0;
    while (!w && rsp_valid_q !== 1'b1) @(negedge mclk);
    while (req_ready_q !== 1'b1) @(negedge mclk);
  endtask

  function automatic int nxt(input int a);
    int n;
    n = a + 1;
    if (n >= hole_base && n < hole_limit) n = hole_limit;
    if (n >= mem_top) n = 2;
    return n;
  endfunction

  initial
  begin
    int a, k, b, w0, r0;
    logic [63:0] d;
    logic [71:0] m, old;
    void'($urandom(32'h9A71));
    repeat (4) @(negedge mclk);
    reset_n = 1'b1;
    repeat (2) @(negedge mclk);
    reg_rd(12'h17A, 32'(PER) << 8);
    reg_rd(12'h17B, 32'h0);
    reg_rd(12'h17C, 32'h0);
    reg_rd(12'h123, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      d = (i == 1) ? 64'h0 : (i == 2) ? '1 : {$urandom, $urandom};
      shadow[i] = d;
      req(1'b1, 1'b0, i, d);
      chk("wr_addr", wr_addr, i);
      chk("wr_plain", wr_data[63:0], d);
    end
    for (int i = 0; i < 16; i++)
    begin
      a = $urandom_range(0, 15);
      k = i % 4;
      b = (i == 1) ? 71 : (i == 5) ? 0 : $urandom_range(0, 70);
      m = (k == 0) ? '0 : 72'(1) << b;
      if (k == 2) m = m | (72'(1) << (b + 1));
      w0 = n_wr;
      old = dram_model_inst.mem[a];
      dram_model_inst.mem[a] = old ^ m;
      req(1'b0, k == 3, a, '0);
      chk("rsp_ce", rsp_ce_q, k == 1 || k == 3);
      chk("rsp_ue", rsp_ue_q, k == 2);
      if (k != 2) chk("rsp_data", rsp_data_q, shadow[a]);
      chk("rsp_dirty", rsp_dirty_q, k == 1);
      chk("scrub_cnt", n_wr - w0, k == 1);
      if (k == 1) chk("scrub_data", wr_data, old);
      if (k > 1) dram_model_inst.mem[a] = old;
    end
    reg_wr(12'h17C, 32'h0001_0000);
    req(1'b1, 1'b0, 3, 64'h0);
    chk("balance", $countones(wr_data) inside {[20:52]}, 1);
    dram_model_inst.mem[3] ^= 72'(1) << 9;
    req(1'b0, 1'b0, 3, '0);
    chk("descramble", rsp_data_q, 0);
    chk("descr_ce", rsp_ce_q, 1);
    reg_wr(12'h17C, 32'h0);
    req(1'b1, 1'b0, 3, shadow[3]);
    old = dram_model_inst.mem[7];
    dram_model_inst.mem[7] = old ^ (72'(1) << 40);
    rd_q.delete();
    rd_t.delete();
    w0 = n_wr;
    r0 = n_rsp;
    d = rsp_data_q;
    slow = 1'b1;
    reg_wr(12'h17B, 32'h2);
    reg_wr(12'h17A, (32'(PER) << 8) | 32'h1);
    reg_rd(12'h17A, (32'(PER) << 8) | 32'h1);
    while (rd_q.size() < 20) @(negedge mclk);
    a = 2;
    for (int i = 0; i < 20; i++)
    begin
      chk("patrol_addr", rd_q[i], a);
      if (i > 0) chk("patrol_gap", rd_t[i] - rd_t[i - 1] >= PER, 1);
      a = nxt(a);
    end
    chk("patrol_rsp", n_rsp - r0, 0);
    chk("patrol_hidden", rsp_data_q, d);
    chk("patrol_fix_n", n_wr - w0, 1);
    chk("patrol_fix", wr_data, old);
    slow = 1'b0;
    self_refresh = 1'b1;
    repeat (3) @(negedge mclk);
    a = rd_q.size();
    repeat (4 * PER) @(negedge mclk);
    chk("sr_quiet", rd_q.size() - a, 0);
    self_refresh = 1'b0;
    repeat (3 * PER) @(negedge mclk);
    chk("sr_resume", rd_q.size() > a, 1);
    reg_wr(12'h17A, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
